//--- vsp_pkg.sv
// Constants and carrier types of the video status and plane compositor.
// Assumes one pixel clock drives the whole block.
package vsp_pkg;
  // Register indices on the plain register port
  localparam logic [3:0] REG_CTRL0 = 4'h0;
  localparam logic [3:0] REG_CTRL1 = 4'h1;
  localparam logic [3:0] REG_COLR = 4'h7;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // Field positions
  localparam int CTRL0_EXT_BIT = 0;
  localparam int CTRL0_MODE_C_BIT = 1;
  localparam int CTRL1_MAG_BIT = 0;
  localparam int CTRL1_SIZE_BIT = 1;
  localparam int CTRL1_MODE_B_BIT = 3;
  localparam int CTRL1_MODE_A_BIT = 4;
  localparam int CTRL1_IRQ_BIT = 5;
  localparam int CTRL1_SHOW_BIT = 6;
  localparam int ST_FRAME_BIT = 7;
  localparam int ST_EXCESS_BIT = 6;
  localparam int ST_OVERLAP_BIT = 5;
  // Horizontal timing in pixel clocks
  localparam int H_TOTAL = 342;
  localparam int H_ACT_GFX = 256;
  localparam int H_RBORD_GFX = 15;
  localparam int H_ACT_TXT = 240;
  localparam int H_RBORD_TXT = 25;
  localparam int H_RBLANK = 8;
  localparam int H_SYNC = 26;
  localparam int H_LBLANK1 = 2;
  localparam int H_BURST = 14;
  localparam int H_LBLANK2 = 8;
  // Vertical timing in lines
  localparam int V_TOTAL = 262;
  localparam int V_ACT = 192;
  localparam int V_BBORD = 24;
  localparam int V_BBLANK = 3;
  localparam int V_SYNC = 13;
  localparam int V_TBLANK = 27;
  localparam int V_EXCESS_LAST = 192;
  localparam int FRAME_RATE_HZ = 60;
  localparam int SPR_LINE_MAX = 4;
  // Colour codes
  localparam logic [3:0] COL_CLEAR = 4'h0;
  localparam logic [3:0] COL_BLACK = 4'h1;

  typedef enum logic [1:0] {
    VSP_GFX1 = 2'b00,
    VSP_GFX2 = 2'b01,
    VSP_MULTI = 2'b10,
    VSP_TEXT = 2'b11
  } vsp_mode_t;

  typedef struct packed {
    logic [31:0] on_line;
    logic [31:0] hit;
    logic [31:0][3:0] colour;
  } vsp_spr_t;

  typedef struct packed {
    logic bit_set;
    logic [3:0] fg;
    logic [3:0] bg;
  } vsp_pat_t;

  typedef struct packed {
    logic hsync;
    logic vsync;
    logic blank;
    logic burst;
    logic active;
  } vsp_sync_t;
endpackage

//--- vsp_video_processor.sv
// Status word, raster timing and plane compositor of the video processor.
// Assumes sprite and pattern fetchers on the same clock feed per-pixel data.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// Behaviour
// - One 8-bit status word holds frame, overlap, excess flags and index.
// - A status read clears the frame flag even when unsynchronised.
// - Frame flag sets when the last active line has been scanned.
// - Frame flag clears on status read or reset.
// - Interrupt output is low while interrupt allowed and frame flag set.
// - Overlap flag sets when two shown sprites share a pixel.
// - Overlap flag clears on status read or reset.
// - Excess flag sets on five sprites in lines 0-192 while frame clear.
// - Excess flag clears on status read or reset.
// - Fifth sprite index loads into low five bits as the flag sets.
// - The excess flag never raises the interrupt.
// - Non-interlaced raster of 262 lines, about 60 frames a second.
// - Graphic lines: 256,15,8,26,2,14,8,13 clocks, 342 total.
// - Text lines: 240 active, 25 right, 19 left border, same blanking.
// - Frame: 192 active, 24 border, 3 blank, 13 sync, rest top.
// - Priority sprite 0..31, pattern, backdrop, external video.
// - Only four sprites per line shown; later ones transparent.
// - No sprites in text mode; size 8, 16 or 32 pixels.
// - Backdrop from colour register; transparent shows black unless external.
// - Cell grids 32x24 of 8x8, text 40x24 of 6x8, multi 64x48 of 4x4.
// - Graphics I 256 definitions, Graphics II 768 with per-line colours.
// - Three mode bits pick Graphics I, II, multicolour or text.
// - Colour register low nibble backdrop, high nibble text foreground.
// - External-video bit enables the external video input.
module vsp_video_processor (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  output logic irq_n_out,
  input wire vsp_pkg::vsp_spr_t spr_in,
  input wire vsp_pkg::vsp_pat_t pat_in,
  input wire logic [3:0] ext_colour_in,
  output vsp_pkg::vsp_sync_t sync_out,
  output logic [8:0] hpos_out,
  output logic [8:0] vpos_out,
  output vsp_pkg::vsp_mode_t mode_out,
  output logic [5:0] cell_col_out,
  output logic [5:0] cell_row_out,
  output logic [9:0] cell_pos_out,
  output logic [1:0] def_bank_out,
  output logic [1:0] spr_size_out,
  output logic [3:0] pixel_out
);

  ////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic vsp_pkg::vsp_mode_t mode_of(input logic [2:0] abc);
    case (abc)
      3'b000: mode_of = vsp_pkg::VSP_GFX1;
      3'b001: mode_of = vsp_pkg::VSP_GFX2;
      3'b010: mode_of = vsp_pkg::VSP_MULTI;
      3'b100: mode_of = vsp_pkg::VSP_TEXT;
      default: mode_of = vsp_pkg::VSP_GFX1;
    endcase
  endfunction

  // First four listed sprites pass; also flags a fifth and its index
  function automatic logic [37:0] line_pick(input logic [31:0] on);
    logic [31:0] keep;
    logic [2:0] seen;
    logic fifth;
    logic [4:0] idx;
    keep = 32'h0000_0000;
    seen = 3'h0;
    fifth = 1'b0;
    idx = 5'h00;
    for (int i = 0; i < 32; i++) begin
      if (on[i]) begin
        if (seen < 3'(vsp_pkg::SPR_LINE_MAX)) begin
          keep[i] = 1'b1;
          seen = seen + 3'h1;
        end else if (!fifth) begin
          fifth = 1'b1;
          idx = 5'(i);
        end
      end
    end
    line_pick = {fifth, idx, keep};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0] ctrl0;
  logic [7:0] ctrl1;
  logic [7:0] colr;
  logic frame_flag;
  logic overlap_flag;
  logic excess_flag;
  logic [4:0] fifth_idx;
  logic [8:0] hcnt;
  logic [8:0] vcnt;
  logic [31:0] line_keep;
  logic [3:0] ext_meta;
  logic [3:0] ext_sync;

  wire rd_status = rd_in && (addr_in == vsp_pkg::REG_STATUS);
  wire [7:0] status_word = {frame_flag, excess_flag, overlap_flag,
                            fifth_idx};
  wire irq_allow_bit = ctrl1[vsp_pkg::CTRL1_IRQ_BIT];
  wire ext_enable = ctrl0[vsp_pkg::CTRL0_EXT_BIT];
  wire [2:0] mode_bits = {ctrl1[vsp_pkg::CTRL1_MODE_A_BIT],
                          ctrl1[vsp_pkg::CTRL1_MODE_B_BIT],
                          ctrl0[vsp_pkg::CTRL0_MODE_C_BIT]};
  wire vsp_pkg::vsp_mode_t mode = mode_of(mode_bits);
  wire text_mode = (mode == vsp_pkg::VSP_TEXT);

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl0 <= vsp_pkg::CTRL_RESET;
      ctrl1 <= vsp_pkg::CTRL_RESET;
      colr <= vsp_pkg::CTRL_RESET;
    end else if (wr_in) begin
      if (addr_in == vsp_pkg::REG_CTRL0) ctrl0 <= wdata_in;
      if (addr_in == vsp_pkg::REG_CTRL1) ctrl1 <= wdata_in;
      if (addr_in == vsp_pkg::REG_COLR) colr <= wdata_in;
    end
  end

  // Read data stand in the cycle after the strobe only
  wire [7:0] rd_mux =
    !rd_in ? 8'h00 :
    (addr_in == vsp_pkg::REG_STATUS) ? status_word :
    (addr_in == vsp_pkg::REG_CTRL0) ? ctrl0 :
    (addr_in == vsp_pkg::REG_CTRL1) ? ctrl1 :
    (addr_in == vsp_pkg::REG_COLR) ? colr : 8'h00;

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) rdata_out <= 8'h00;
    else rdata_out <= rd_mux;
  end

  ////////////////////////////////////////////////////////////////////////
  // Raster counters

  localparam logic [8:0] H_LAST = 9'(vsp_pkg::H_TOTAL - 1);
  localparam logic [8:0] V_LAST = 9'(vsp_pkg::V_TOTAL - 1);
  localparam logic [8:0] V_ACT_LAST = 9'(vsp_pkg::V_ACT - 1);
  wire line_end = (hcnt == H_LAST);

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hcnt <= 9'h000;
      vcnt <= 9'h000;
    end else begin
      hcnt <= line_end ? 9'h000 : hcnt + 9'h001;
      if (line_end) vcnt <= (vcnt == V_LAST) ? 9'h000 : vcnt + 9'h001;
    end
  end

  // Horizontal edges; text mode only moves the active and border widths
  wire [8:0] h_act = text_mode ? 9'(vsp_pkg::H_ACT_TXT)
                               : 9'(vsp_pkg::H_ACT_GFX);
  wire [8:0] h_rb = text_mode ? 9'(vsp_pkg::H_RBORD_TXT)
                              : 9'(vsp_pkg::H_RBORD_GFX);
  wire [8:0] h_bl0 = h_act + h_rb;
  wire [8:0] h_sy0 = h_bl0 + 9'(vsp_pkg::H_RBLANK);
  wire [8:0] h_sy1 = h_sy0 + 9'(vsp_pkg::H_SYNC);
  wire [8:0] h_bu0 = h_sy1 + 9'(vsp_pkg::H_LBLANK1);
  wire [8:0] h_bu1 = h_bu0 + 9'(vsp_pkg::H_BURST);
  wire [8:0] h_lb0 = h_bu1 + 9'(vsp_pkg::H_LBLANK2);
  localparam logic [8:0] V_BL0 = 9'(vsp_pkg::V_ACT + vsp_pkg::V_BBORD);
  localparam logic [8:0] V_SY0 = V_BL0 + 9'(vsp_pkg::V_BBLANK);
  localparam logic [8:0] V_SY1 = V_SY0 + 9'(vsp_pkg::V_SYNC);
  localparam logic [8:0] V_TB1 = V_SY1 + 9'(vsp_pkg::V_TBLANK);

  wire h_active = (hcnt < h_act);
  wire h_blank = (hcnt >= h_bl0) && (hcnt < h_lb0);
  wire v_active = (vcnt < 9'(vsp_pkg::V_ACT));
  wire v_blank = (vcnt >= V_BL0) && (vcnt < V_TB1);
  wire pix_active = h_active && v_active &&
                    ctrl1[vsp_pkg::CTRL1_SHOW_BIT];

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) sync_out <= '0;
    else begin
      sync_out.hsync <= (hcnt >= h_sy0) && (hcnt < h_sy1);
      sync_out.vsync <= (vcnt >= V_SY0) && (vcnt < V_SY1);
      sync_out.blank <= h_blank || v_blank;
      sync_out.burst <= (hcnt >= h_bu0) && (hcnt < h_bu1);
      sync_out.active <= pix_active;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pattern plane addressing

  wire [8:0] col_txt = 9'(hcnt / 9'd6);
  wire [5:0] cols = text_mode ? 6'd40 : 6'd32;
  always_comb begin
    case (mode)
      vsp_pkg::VSP_TEXT: begin
        cell_col_out = col_txt[5:0];
        cell_row_out = {1'b0, vcnt[7:3]};
      end
      vsp_pkg::VSP_MULTI: begin
        cell_col_out = hcnt[7:2];
        cell_row_out = vcnt[7:2];
      end
      default: begin
        cell_col_out = {1'b0, hcnt[7:3]};
        cell_row_out = {1'b0, vcnt[7:3]};
      end
    endcase
  end
  wire [11:0] pos_full = 12'(cell_row_out[4:0] * cols) + 12'(cell_col_out);
  assign cell_pos_out = pos_full[9:0];
  // Graphics II splits the screen in thirds of 256 definitions each
  assign def_bank_out = (mode == vsp_pkg::VSP_GFX2) ? vcnt[7:6]
                                                    : 2'b00;
  assign spr_size_out = {ctrl1[vsp_pkg::CTRL1_SIZE_BIT],
                         ctrl1[vsp_pkg::CTRL1_MAG_BIT]};
  assign hpos_out = hcnt;
  assign vpos_out = vcnt;
  assign mode_out = mode;

  ////////////////////////////////////////////////////////////////////////
  // Sprite selection and status flags

  wire [37:0] pick = line_pick(spr_in.on_line);
  wire pick_fifth = pick[37];
  wire line_start = (hcnt == 9'h000);
  wire excess_line = line_start && pick_fifth &&
                     (vcnt <= 9'(vsp_pkg::V_EXCESS_LAST));
  wire excess_set = excess_line && !frame_flag && !text_mode;
  wire frame_set = line_end && (vcnt == V_ACT_LAST);
  wire [31:0] shown = spr_in.hit & line_keep;
  wire overlap_set = ((shown & (shown - 32'h1)) != 32'h0) &&
                     !text_mode;

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) line_keep <= 32'h0000_0000;
    else if (line_start) line_keep <= pick[31:0];
  end

  // Hardware set wins over the read clear in the same cycle
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      frame_flag <= 1'b0;
      overlap_flag <= 1'b0;
      excess_flag <= 1'b0;
      fifth_idx <= 5'h00;
    end else begin
      frame_flag <= frame_set || (frame_flag && !rd_status);
      overlap_flag <= overlap_set ||
                      (overlap_flag && !rd_status);
      excess_flag <= excess_set ||
                     (excess_flag && !rd_status);
      if (excess_set && !(excess_flag && !rd_status))
        fifth_idx <= pick[36:32];
    end
  end

  // Only the frame flag reaches the pin; reading mid-frame can lose it
  assign irq_n_out = !(irq_allow_bit && frame_flag);

  ////////////////////////////////////////////////////////////////////////
  // Compositor

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ext_meta <= 4'h0;
      ext_sync <= 4'h0;
    end else begin
      ext_meta <= ext_colour_in;
      ext_sync <= ext_meta;
    end
  end

  logic [3:0] spr_colour;
  logic spr_found;
  always_comb begin
    spr_colour = vsp_pkg::COL_CLEAR;
    spr_found = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      if (shown[i] && spr_in.colour[i] != vsp_pkg::COL_CLEAR) begin
        spr_found = !text_mode;
        spr_colour = spr_in.colour[i];
      end
    end
  end

  wire [3:0] backdrop = colr[3:0];
  wire [3:0] txt_fg = colr[7:4];
  wire [3:0] pat_colour = text_mode ? (pat_in.bit_set ? txt_fg : backdrop) :
                          (pat_in.bit_set ? pat_in.fg : pat_in.bg);
  wire [3:0] back_colour =
    (backdrop != vsp_pkg::COL_CLEAR) ? backdrop :
    ext_enable ? ext_sync : vsp_pkg::COL_BLACK;
  wire [3:0] next_pixel =
    !pix_active ? back_colour :
    spr_found ? spr_colour :
    (pat_colour != vsp_pkg::COL_CLEAR) ? pat_colour : back_colour;

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) pixel_out <= vsp_pkg::COL_BLACK;
    else pixel_out <= next_pixel;
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_status_read;
    rd_in && (addr_in == vsp_pkg::REG_STATUS);
  endsequence

  chk_read_old_flags: assert property (
    @(posedge ref_clk_in) disable iff (!resetn_in)
    s_status_read |=> rdata_out == $past(status_word))
    else $error("status read did not return prior flags");

  chk_read_clears: assert property (
    @(posedge ref_clk_in) disable iff (!resetn_in)
    s_status_read ##0 !frame_set |=> !frame_flag)
    else $error("frame flag survived a status read");

  chk_frame_sets: assert property (
    @(posedge ref_clk_in) disable iff (!resetn_in)
    (hcnt == H_LAST && vcnt == V_ACT_LAST) |=> frame_flag ##1 1'b1)
    else $error("frame flag not set at end of active area");

  chk_irq_pin: assert property (
    @(posedge ref_clk_in) disable iff (!resetn_in)
    (frame_flag && irq_allow_bit) == !irq_n_out)
    else $error("interrupt pin does not follow frame flag");

  chk_excess_no_irq: assert property (
    @(posedge ref_clk_in) disable iff (!resetn_in)
    $rose(excess_flag) && !frame_flag |-> irq_n_out)
    else $error("excess flag raised the interrupt");

  chk_excess_gate: assert property (
    @(posedge ref_clk_in) disable iff (!resetn_in)
    $rose(excess_flag) |-> $past(!frame_flag) &&
                           $past(vcnt) <= 9'(vsp_pkg::V_EXCESS_LAST))
    else $error("excess flag set outside its window");

  chk_fifth_index: assert property (
    @(posedge ref_clk_in) disable iff (!resetn_in)
    $rose(excess_flag) |-> fifth_idx == $past(pick[36:32]))
    else $error("fifth sprite index not loaded");

  chk_line_wrap: assert property (
    @(posedge ref_clk_in) disable iff (!resetn_in)
    line_end |=> hcnt == 9'h000 ##1 hcnt == 9'h001)
    else $error("line length is not 342 clocks");

  chk_frame_wrap: assert property (
    @(posedge ref_clk_in) disable iff (!resetn_in)
    (line_end && vcnt == V_LAST) |=> vcnt == 9'h000)
    else $error("frame length is not 262 lines");

  chk_four_shown: assert property (
    @(posedge ref_clk_in) disable iff (!resetn_in)
    $countones(line_keep) <= vsp_pkg::SPR_LINE_MAX)
    else $error("more than four sprites on a line");

endmodule // vsp_video_processor

//--- vsp_host_model.sv
// Host model: drives the register port and services the frame interrupt.
// Assumes the bench calls the bus tasks from one process at a time.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
module vsp_host_model (
  input wire logic ref_clk_in,
  input wire logic irq_n_in,
  output logic [3:0] addr_out,
  output logic [7:0] wdata_out,
  output logic wr_out,
  output logic rd_out
);
  logic [7:0] exp_q[$];
  logic svc_en;
  logic [7:0] svc_exp;

  initial begin
    addr_out = 4'h0;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
    svc_en = 1'b0;
    svc_exp = 8'h00;
  end

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge ref_clk_in);
    wr_out <= 1'b0;
    // Idle bus shows the inverse, so a stale word cannot pass for a new one
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask

  task automatic reg_read(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    exp_q.push_back(e);
    @(posedge ref_clk_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Status is read only while the frame interrupt is pending
  initial begin
    forever begin
      @(posedge ref_clk_in);
      if (svc_en && irq_n_in === 1'b0) begin
        svc_en = 1'b0;
        reg_read(vsp_pkg::REG_STATUS, svc_exp);
      end
    end
  end
endmodule // vsp_host_model

//--- video_status_and_plane_compositor_test.sv
// Self-checking bench for the video processor with a host model.
// Assumes the design's package is compiled first; one 25 MHz clock.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
module video_status_and_plane_compositor_test;
  logic ref_clk_in;
  logic resetn;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic irq_n;
  vsp_pkg::vsp_spr_t spr;
  vsp_pkg::vsp_pat_t pat;
  logic [3:0] ext;
  vsp_pkg::vsp_sync_t sync;
  logic [8:0] hpos;
  logic [8:0] vpos;
  vsp_pkg::vsp_mode_t mode;
  logic [3:0] pixel;
  logic [5:0] cell_col;
  logic [5:0] cell_row;
  logic [9:0] cell_pos;
  logic [1:0] def_bank;
  logic [1:0] spr_size;
  int mismatches = 0;
  int tests_run = 0;
  int seed;
  logic rd_pend = 1'b0;
  logic [31:0] r;
  logic [31:0] on;
  logic [7:0] col;
  logic [3:0] pf;
  logic [4:0] k0;
  logic [4:0] k1;
  logic [4:0] k4;
  logic [31:0][3:0] cl;

  vsp_video_processor vsp_video_processor_inst (
    .ref_clk_in(ref_clk_in), .resetn_in(resetn), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .irq_n_out(irq_n), .spr_in(spr), .pat_in(pat), .ext_colour_in(ext),
    .sync_out(sync), .hpos_out(hpos), .vpos_out(vpos), .mode_out(mode),
    .cell_col_out(cell_col), .cell_row_out(cell_row),
    .cell_pos_out(cell_pos), .def_bank_out(def_bank),
    .spr_size_out(spr_size), .pixel_out(pixel)
  );

  vsp_host_model host_inst (
    .ref_clk_in(ref_clk_in), .irq_n_in(irq_n), .addr_out(addr),
    .wdata_out(wdata), .wr_out(wr), .rd_out(rd)
  );

  initial begin
    ref_clk_in = 1'b0;
    forever #20 ref_clk_in = ~ref_clk_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (mismatches == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: read %h not %h", $time, got, exp);
    end
  endtask

  task automatic cmp_px(input logic [3:0] got, input logic [3:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: pixel %h not %h", $time, got, exp);
    end
  endtask

  task automatic cmp_val(input logic [9:0] got, input logic [9:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: level %h not %h", $time, got, exp);
    end
  endtask

  function automatic logic [4:0] nth(input logic [31:0] v, input int n);
    int c;
    nth = 5'h00;
    c = 0;
    for (int i = 0; i < 32; i++) begin
      if (v[i]) begin
        c++;
        if (c == n) nth = 5'(i);
      end
    end
  endfunction

  task automatic to_pos(input int h, input int v);
    int n;
    n = 0;
    @(negedge ref_clk_in);
    while (!(hpos === h[8:0] && vpos === v[8:0])) begin
      n++;
      if (n > 100000) begin
        mismatches++;
        close_out();
      end
      @(negedge ref_clk_in);
    end
  endtask

  // Four edges cover the two-flop external path plus the output flop
  task automatic px(input logic [3:0] e);
    repeat (4) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    cmp_px(pixel, e);
  endtask

  task automatic count_line(input logic [9:0] act);
    logic [9:0] a;
    logic [9:0] s;
    logic [9:0] b;
    a = 10'h000;
    s = 10'h000;
    b = 10'h000;
    repeat (342) begin
      @(negedge ref_clk_in);
      a = a + sync.active;
      s = s + sync.hsync;
      b = b + sync.burst;
    end
    cmp_val(a, act);
    cmp_val(s, 10'h01a);
    cmp_val(b, 10'h00e);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Read data stand only in the cycle after the strobe
  always @(negedge ref_clk_in) begin
    if (rd_pend) begin
      cmp_rd(rdata, host_inst.exp_q.pop_front());
    end else begin
      cmp_rd(rdata, 8'h00);
    end
    rd_pend = rd;
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    seed = 46359;
    resetn = 1'b0;
    spr = '0;
    pat = '0;
    ext = 4'h0;
    repeat (8) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    cmp_val({9'h000, irq_n}, 10'h001);
    cmp_px(pixel, 4'h1);
    cmp_val({1'b0, hpos}, 10'h000);
    @(posedge ref_clk_in);
    resetn <= 1'b1;
    r = $random(seed);
    col = r[7:0] | 8'h11;
    pf = r[11:8] | 4'h1;
    ext <= r[15:12];
    host_inst.reg_write(vsp_pkg::REG_COLR, col);
    host_inst.reg_read(vsp_pkg::REG_STATUS, 8'h00);
    host_inst.reg_write(vsp_pkg::REG_STATUS, 8'hff);
    host_inst.reg_read(vsp_pkg::REG_STATUS, 8'h00);
    host_inst.reg_read(4'h3, 8'h00);
    for (int i = 0; i < 4; i++) begin
      host_inst.reg_write(vsp_pkg::REG_CTRL0, (i == 1) ? 8'h02 : 8'h00);
      host_inst.reg_write(vsp_pkg::REG_CTRL1,
        (i == 2) ? 8'h6b : ((i == 3) ? 8'h70 : 8'h60));
      @(negedge ref_clk_in);
      cmp_val({8'h00, mode}, 10'(i));
      cmp_val({8'h00, spr_size}, (i == 2) ? 10'h003 : 10'h000);
    end
    // Graphics I is selected again; graphics timing is measured next
    host_inst.reg_write(vsp_pkg::REG_CTRL1, 8'h60);
    to_pos(0, 3);
    count_line(10'h100);
    // Five fixed bits guarantee an excess line whatever the seed gives
    on = $random(seed) | 32'h81020408;
    k0 = nth(on, 1);
    k1 = nth(on, 2);
    k4 = nth(on, 5);
    for (int i = 0; i < 32; i++) cl[i] = 4'($random(seed)) | 4'h1;
    cl[k0] = 4'h0;
    to_pos(300, 9);
    @(posedge ref_clk_in);
    spr.on_line <= on;
    spr.colour <= cl;
    pat <= '{1'b1, pf, 4'h0};
    to_pos(5, 10);
    host_inst.reg_read(vsp_pkg::REG_STATUS, {3'b010, k4});
    cmp_val({9'h000, irq_n}, 10'h001);
    host_inst.reg_read(vsp_pkg::REG_STATUS, {3'b000, k4});
    @(posedge ref_clk_in);
    spr.hit <= '1;
    px(cl[k1]);
    @(posedge ref_clk_in);
    spr.hit <= 32'h1 << k4;
    px(pf);
    host_inst.reg_read(vsp_pkg::REG_STATUS, {3'b001, k4});
    host_inst.reg_read(vsp_pkg::REG_STATUS, {3'b000, k4});
    @(posedge ref_clk_in);
    pat <= '{1'b0, pf, 4'h0};
    px(col[3:0]);
    host_inst.reg_write(vsp_pkg::REG_COLR, {col[7:4], 4'h0});
    px(4'h1);
    host_inst.reg_write(vsp_pkg::REG_CTRL0, 8'h01);
    px(ext);
    host_inst.reg_write(vsp_pkg::REG_CTRL0, 8'h00);
    host_inst.reg_write(vsp_pkg::REG_COLR, col);
    to_pos(10, 12);
    cmp_val(cell_pos, 10'h021);
    cmp_val({cell_row[3:0], cell_col}, 10'h041);
    host_inst.reg_write(vsp_pkg::REG_CTRL1, 8'h70);
    @(posedge ref_clk_in);
    spr.hit <= '1;
    pat <= '{1'b1, pf, 4'h0};
    px(col[7:4]);
    @(posedge ref_clk_in);
    spr.hit <= '0;
    to_pos(0, 14);
    cmp_val(cell_pos, 10'h028);
    count_line(10'h0f0);
    host_inst.reg_write(vsp_pkg::REG_CTRL1, 8'h60);
    to_pos(341, 191);
    cmp_val({9'h000, irq_n}, 10'h001);
    @(negedge ref_clk_in);
    cmp_val({9'h000, irq_n}, 10'h000);
    cmp_val({hpos, vpos[0]}, 10'h000);
    cmp_val({1'b0, vpos}, 10'h0c0);
    host_inst.reg_write(vsp_pkg::REG_CTRL1, 8'h40);
    @(negedge ref_clk_in);
    cmp_val({9'h000, irq_n}, 10'h001);
    host_inst.svc_exp = {3'b110, k4};
    host_inst.svc_en = 1'b1;
    host_inst.reg_write(vsp_pkg::REG_CTRL1, 8'h60);
    n = 0;
    while (irq_n !== 1'b1 || host_inst.svc_en !== 1'b0) begin
      n++;
      if (n > 20) begin
        mismatches++;
        close_out();
      end
      @(negedge ref_clk_in);
    end
    to_pos(100, 193);
    cmp_val({9'h000, irq_n}, 10'h001);
    host_inst.reg_read(vsp_pkg::REG_STATUS, {3'b000, k4});
    host_inst.reg_write(vsp_pkg::REG_CTRL0, 8'h02);
    @(negedge ref_clk_in);
    cmp_val({8'h00, def_bank}, 10'h003);
    @(posedge ref_clk_in);
    spr.hit <= '1;
    repeat (3) @(posedge ref_clk_in);
    spr <= '0;
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    resetn <= 1'b1;
    host_inst.reg_read(vsp_pkg::REG_STATUS, 8'h00);
    repeat (2) @(negedge ref_clk_in);
    close_out();
  end
endmodule // video_status_and_plane_compositor_test
